// >>> core/cmp_channel.v
`timescale 1ns/1ps
// One comparator's digital path: synchroniser, polarity, timer capture, edges
module cmp_channel (
  input  wire clk_i,
  input  wire rst_n_i,
  input  wire raw_i,
  input  wire enable_i,
  input  wire invert_i,
  input  wire sync_en_i,
  input  wire tmr_fall_i,
  input  wire rise_en_i,
  input  wire fall_en_i,
  output wire result_o,
  output wire gated_o,
  output wire event_o
);

  reg  meta_q;
  reg  sync_q;
  reg  result_q;
  reg  prev_q;
  reg  capt_q;
  reg  event_q;
  wire result_d;
  wire rise;
  wire fall;

  // Analog result is asynchronous to the clock
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
    end else begin
      meta_q <= raw_i;
      sync_q <= meta_q;
    end
  end

  // Disabled comparator reads low before inversion
  assign result_d = (enable_i & sync_q) ^ invert_i;

  // Latched once per cycle
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      result_q <= 1'b0;
      prev_q   <= 1'b0;
    end else begin
      result_q <= result_d;
      prev_q   <= result_q;
    end
  end

  // Edges seen after polarity, even while disabled
  assign rise = result_q & ~prev_q;
  assign fall = ~result_q & prev_q;

  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      event_q <= 1'b0;
    end else begin
      event_q <= (rise & rise_en_i) | (fall & fall_en_i);
    end
  end

  // Capture on falling edge of the prescaled timer clock
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      capt_q <= 1'b0;
    end else if (tmr_fall_i) begin
      capt_q <= result_q;
    end
  end

  assign gated_o  = sync_en_i ? capt_q : result_q;
  assign result_o = result_q;
  assign event_o  = event_q;

endmodule // cmp_channel

// >>> core/cmp_control.v
// What this block does
// - Hysteresis output follows control A bit 1
// - Sync bit: capture result on timer falling edge
// - Capture uses post-prescaler timer clock
// - Rise/fall detectors set flag when enabled
// - New edge beats simultaneous flag clear
// - Enable bit 7 powers comparator and inputs
// - Edges watched after polarity, even disabled
// - Positive select bits 5-4 to multiplexer
// - Negative select bits 1-0 to multiplexer
// - Result bit 6, inverted by polarity bit
// - Drive enable bit 5 overrides pin latch
// - Mirror register holds both result bits
// - Speed bit 2 resets to one
// - Sync set: update only on timer fall
// - Internal result latched every cycle
//
// Strobed register access and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`include "cmp_regs.vh"

module cmp_control (
  input  wire       CLK_I,
  input  wire       RESETN_I,
  input  wire [2:0] ADDR_I,
  input  wire [7:0] WDATA_I,
  input  wire       WR_I,
  input  wire       RD_I,
  input  wire [1:0] CMP_RAW_I,
  input  wire       TMR_CLK_I,
  input  wire [1:0] PIN_DIR_I,
  output reg  [7:0] RDATA_O,
  output reg  [1:0] CMP_ENABLE_O,
  output reg  [1:0] CMP_HYST_O,
  output reg  [1:0] CMP_SPEED_O,
  output reg  [3:0] CMP_POS_SEL_O,
  output reg  [3:0] CMP_NEG_SEL_O,
  output reg  [1:0] CMP_GATE_O,
  output reg  [1:0] PIN_OUT_O,
  output reg  [1:0] PIN_OE_N_O,
  output reg        IRQ_O
);

  reg        rst_meta_q;
  reg        rst_sync_q;
  wire       rst_n;
  reg        tmr_meta_q;
  reg        tmr_sync_q;
  reg        tmr_prev_q;
  wire       tmr_fall;
  reg  [7:0] ctrl_a1_q;
  reg  [7:0] ctrl_a2_q;
  reg  [7:0] ctrl_b1_q;
  reg  [7:0] ctrl_b2_q;
  reg  [1:0] flag_q;
  reg  [1:0] flag_d;
  reg  [1:0] mask_q;
  reg  [1:0] mask_d;
  reg  [7:0] rdata_d;
  wire       wr_a1;
  wire       wr_a2;
  wire       wr_b1;
  wire       wr_b2;
  wire       wr_mask;
  wire       rd_flags;
  wire [1:0] result;
  wire [1:0] gated;
  wire [1:0] hit;
  wire [1:0] enable;
  wire [1:0] invert;
  wire [1:0] sync_en;
  wire [1:0] rise_en;
  wire [1:0] fall_en;
  wire [1:0] pin_drive;
  wire [7:0] ctrl_a1_rd;
  wire [7:0] ctrl_a2_rd;
  wire [7:0] mirror_rd;

  // Reset release through two flops
  always @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  assign rst_n = rst_sync_q;

  // Timer clock arrives already prescaled, so no prescaler logic here
  always @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      tmr_meta_q <= 1'b0;
      tmr_sync_q <= 1'b0;
      tmr_prev_q <= 1'b0;
    end else begin
      tmr_meta_q <= TMR_CLK_I;
      tmr_sync_q <= tmr_meta_q;
      tmr_prev_q <= tmr_sync_q;
    end
  end

  assign tmr_fall = tmr_prev_q & ~tmr_sync_q;

  // Write decode
  assign wr_a1    = WR_I && (ADDR_I == `OFF_CTRL_A_ONE);
  assign wr_a2    = WR_I && (ADDR_I == `OFF_CTRL_A_TWO);
  assign wr_b1    = WR_I && (ADDR_I == `OFF_CTRL_B_ONE);
  assign wr_b2    = WR_I && (ADDR_I == `OFF_CTRL_B_TWO);
  assign wr_mask  = WR_I && (ADDR_I == `OFF_IRQ_MASK);
  assign rd_flags = RD_I && (ADDR_I == `OFF_IRQ_FLAGS);

  // Control A, comparator one; result bit and bit 3 never stored
  always @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_a1_q <= `CA_RESET;
    end else if (wr_a1) begin
      ctrl_a1_q <= WDATA_I & `CA_WMASK;
    end
  end

  // Control A, comparator two
  always @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_a2_q <= `CA_RESET;
    end else if (wr_a2) begin
      ctrl_a2_q <= WDATA_I & `CA_WMASK;
    end
  end

  // Control B, comparator one
  always @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_b1_q <= `CB_RESET;
    end else if (wr_b1) begin
      ctrl_b1_q <= WDATA_I & `CB_WMASK;
    end
  end

  // Control B, comparator two
  always @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_b2_q <= `CB_RESET;
    end else if (wr_b2) begin
      ctrl_b2_q <= WDATA_I & `CB_WMASK;
    end
  end

  // Field extraction, index 0 is comparator one
  assign enable    = {ctrl_a2_q[`CA_ENABLE], ctrl_a1_q[`CA_ENABLE]};
  assign invert    = {ctrl_a2_q[`CA_INVERT], ctrl_a1_q[`CA_INVERT]};
  assign sync_en   = {ctrl_a2_q[`CA_SYNC], ctrl_a1_q[`CA_SYNC]};
  assign pin_drive = {ctrl_a2_q[`CA_PIN_DRIVE], ctrl_a1_q[`CA_PIN_DRIVE]};
  assign rise_en   = {ctrl_b2_q[`CB_RISE], ctrl_b1_q[`CB_RISE]};
  assign fall_en   = {ctrl_b2_q[`CB_FALL], ctrl_b1_q[`CB_FALL]};

  cmp_channel u_ch_one (
    .clk_i      (CLK_I),
    .rst_n_i    (rst_n),
    .raw_i      (CMP_RAW_I[0]),
    .enable_i   (enable[0]),
    .invert_i   (invert[0]),
    .sync_en_i  (sync_en[0]),
    .tmr_fall_i (tmr_fall),
    .rise_en_i  (rise_en[0]),
    .fall_en_i  (fall_en[0]),
    .result_o   (result[0]),
    .gated_o    (gated[0]),
    .event_o    (hit[0])
  );

  cmp_channel u_ch_two (
    .clk_i      (CLK_I),
    .rst_n_i    (rst_n),
    .raw_i      (CMP_RAW_I[1]),
    .enable_i   (enable[1]),
    .invert_i   (invert[1]),
    .sync_en_i  (sync_en[1]),
    .tmr_fall_i (tmr_fall),
    .rise_en_i  (rise_en[1]),
    .fall_en_i  (fall_en[1]),
    .result_o   (result[1]),
    .gated_o    (gated[1]),
    .event_o    (hit[1])
  );

  // Sticky flags: a read clears them, but a new edge in that cycle survives
  always @* begin
    flag_d = flag_q;
    if (rd_flags) begin
      flag_d = 2'h0;
    end
    flag_d = flag_d | hit;
  end

  always @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      flag_q <= `IRQ_RESET;
    end else begin
      flag_q <= flag_d;
    end
  end

  // Per-comparator interrupt enables
  always @* begin
    mask_d = mask_q;
    if (wr_mask) begin
      mask_d = WDATA_I[1:0];
    end
  end

  always @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      mask_q <= `IRQ_RESET;
    end else begin
      mask_q <= mask_d;
    end
  end

  // Read views with the live result in bit 6 of control A, and in bits 1-0 of the mirror
  assign ctrl_a1_rd = {ctrl_a1_q[7], result[0], ctrl_a1_q[5:0]};
  assign ctrl_a2_rd = {ctrl_a2_q[7], result[1], ctrl_a2_q[5:0]};
  assign mirror_rd  = {6'h00, result[1], result[0]};

  // Read decode; unmapped addresses read zero
  always @* begin
    rdata_d = 8'h00;
    if (ADDR_I == `OFF_CTRL_A_ONE) begin
      rdata_d = ctrl_a1_rd;
    end else if (ADDR_I == `OFF_CTRL_A_TWO) begin
      rdata_d = ctrl_a2_rd;
    end else if (ADDR_I == `OFF_CTRL_B_ONE) begin
      rdata_d = ctrl_b1_q;
    end else if (ADDR_I == `OFF_CTRL_B_TWO) begin
      rdata_d = ctrl_b2_q;
    end else if (ADDR_I == `OFF_MIRROR) begin
      rdata_d = mirror_rd;
    end else if (ADDR_I == `OFF_IRQ_FLAGS) begin
      rdata_d = {6'h00, flag_q};
    end else if (ADDR_I == `OFF_IRQ_MASK) begin
      rdata_d = {6'h00, mask_q};
    end
  end

  // Read data valid only in the cycle after the strobe
  always @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      RDATA_O <= 8'h00;
    end else if (RD_I) begin
      RDATA_O <= rdata_d;
    end else begin
      RDATA_O <= 8'h00;
    end
  end

  // Analog control outputs
  always @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      CMP_ENABLE_O <= 2'h0;
      CMP_HYST_O   <= 2'h0;
      CMP_SPEED_O  <= 2'h3;
    end else begin
      CMP_ENABLE_O <= enable;
      CMP_HYST_O   <= {ctrl_a2_q[`CA_HYST], ctrl_a1_q[`CA_HYST]};
      CMP_SPEED_O  <= {ctrl_a2_q[`CA_SPEED], ctrl_a1_q[`CA_SPEED]};
    end
  end

  // Input multiplexer selects, comparator one in the low pair
  always @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      CMP_POS_SEL_O <= 4'h0;
      CMP_NEG_SEL_O <= 4'h0;
    end else begin
      CMP_POS_SEL_O <= {ctrl_b2_q[`CB_POS_HI:`CB_POS_LO],
                        ctrl_b1_q[`CB_POS_HI:`CB_POS_LO]};
      CMP_NEG_SEL_O <= {ctrl_b2_q[`CB_NEG_HI:`CB_NEG_LO],
                        ctrl_b1_q[`CB_NEG_HI:`CB_NEG_LO]};
    end
  end

  // Timer gate feed and pin override; drive enable ignores the enable bit
  always @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      CMP_GATE_O <= 2'h0;
      PIN_OUT_O  <= 2'h0;
      PIN_OE_N_O <= 2'h3;
    end else begin
      CMP_GATE_O <= gated;
      PIN_OUT_O  <= gated;
      PIN_OE_N_O <= ~(pin_drive & ~PIN_DIR_I);
    end
  end

  // Level interrupt from unmasked flags, using next-state values
  always @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      IRQ_O <= 1'b0;
    end else begin
      IRQ_O <= |(flag_d & mask_d);
    end
  end

endmodule // cmp_control

// >>> core/cmp_regs.vh
`ifndef CMP_REGS_VH
`define CMP_REGS_VH

// Register offsets (byte address on the 3-bit register port)
`define OFF_CTRL_A_ONE 3'h0
`define OFF_CTRL_A_TWO 3'h1
`define OFF_CTRL_B_ONE 3'h2
`define OFF_CTRL_B_TWO 3'h3
`define OFF_MIRROR     3'h4
`define OFF_IRQ_FLAGS  3'h5
`define OFF_IRQ_MASK   3'h6

// Control A fields
`define CA_ENABLE      7
`define CA_RESULT      6
`define CA_PIN_DRIVE   5
`define CA_INVERT      4
`define CA_SPEED       2
`define CA_HYST        1
`define CA_SYNC        0
`define CA_WMASK       8'hB7
`define CA_RESET       8'h04

// Control B fields
`define CB_RISE        7
`define CB_FALL        6
`define CB_POS_HI      5
`define CB_POS_LO      4
`define CB_NEG_HI      1
`define CB_NEG_LO      0
`define CB_WMASK       8'hF3
`define CB_RESET       8'h00

// Mirror, flag and mask fields
`define MIR_ONE        0
`define MIR_TWO        1
`define IRQ_RESET      2'h0

`endif

// >>> verification/cmp_control_assertions.sv
`timescale 1ns/1ps
module cmp_control_assertions (
  input wire       CLK_I,
  input wire       RESETN_I,
  input wire [2:0] ADDR_I,
  input wire [7:0] WDATA_I,
  input wire       WR_I,
  input wire       RD_I,
  input wire [1:0] PIN_DIR_I,
  input wire [7:0] RDATA_O,
  input wire [1:0] CMP_HYST_O,
  input wire [3:0] CMP_POS_SEL_O,
  input wire [3:0] CMP_NEG_SEL_O,
  input wire [1:0] CMP_GATE_O,
  input wire [1:0] PIN_OUT_O,
  input wire [1:0] PIN_OE_N_O,
  input wire       IRQ_O
);
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RESETN_I);
  AST_HYST: assert property (WR_I && ADDR_I == 3'h0 |-> ##2
    CMP_HYST_O[0] == $past(WDATA_I[1], 2))
    else $error("hysteresis output wrong");
  AST_POS: assert property (WR_I && ADDR_I == 3'h2 |-> ##2
    CMP_POS_SEL_O[1:0] == $past(WDATA_I[5:4], 2))
    else $error("positive select wrong");
  AST_NEG: assert property (WR_I && ADDR_I == 3'h3 |-> ##2
    CMP_NEG_SEL_O[3:2] == $past(WDATA_I[1:0], 2))
    else $error("negative select wrong");
  AST_MIRROR: assert property (RD_I && ADDR_I == 3'h4 |=> RDATA_O[7:2] == 6'h00)
    else $error("mirror upper bits set");
  AST_CTRLB: assert property (RD_I && ADDR_I[2:1] == 2'h1 |=> RDATA_O[3:2] == 2'h0)
    else $error("control b unused bits set");
  AST_UNMAP: assert property (RD_I && ADDR_I == 3'h7 |=> RDATA_O == 8'h00)
    else $error("unmapped read not zero");
  AST_PIN: assert property (PIN_OUT_O == CMP_GATE_O)
    else $error("pin differs from gate");
  AST_DIR: assert property ((PIN_DIR_I == 2'h3) [*2] |=> PIN_OE_N_O == 2'h3)
    else $error("pin driven while input");
  AST_MASK: assert property (WR_I && ADDR_I == 3'h6 && WDATA_I[1:0] == 2'h0 |=> !IRQ_O)
    else $error("masked interrupt high");
  cover property ($rose(IRQ_O));
  cover property ($fell(CMP_GATE_O[0]));
  cover property (RD_I && ADDR_I == 3'h5);
endmodule // cmp_control_assertions
bind cmp_control cmp_control_assertions cmp_control_assertions_inst (.*);

// >>> verification/cmp_far_side.sv
`timescale 1ns/1ps
module cmp_far_side #(
  parameter int DIV = 4,
  parameter int DLY = 0
) (
  input  wire logic       clk_i,
  input  wire logic [1:0] above_i,
  input  wire logic       tmr_run_i,
  output wire logic [1:0] raw_o,
  output logic            tmr_o
);
  int cnt = 0;
  // Analog decision settles DLY ns after the inputs move
  assign #DLY raw_o = above_i;
  initial tmr_o = 1'b1;
  // Prescaled timer clock, parked high while the timer is stopped
  always @(posedge clk_i) begin
    cnt <= tmr_run_i ? (cnt + 1) % DIV : 0;
    if (!tmr_run_i)
      tmr_o <= 1'b1;
    else if (cnt == DIV - 1)
      tmr_o <= ~tmr_o;
  end
endmodule // cmp_far_side

// >>> verification/tb_cmp_control.sv
`timescale 1ns/1ps
module tb_cmp_control;
  logic       clk = 1'b0;
  logic       rst_n = 1'b0;
  logic [2:0] adr = 3'h0;
  logic [7:0] wd = 8'h00;
  logic       wr = 1'b0;
  logic       rd = 1'b0;
  logic [1:0] ab = 2'h0;
  logic       run = 1'b0;
  logic [1:0] dir = 2'h3;
  logic [1:0] raw, en, hys, spd, gate, pout, oen;
  logic       tmr, irq;
  logic [7:0] rdat, k;
  logic [3:0] psel, nsel;
  int         miscompares = 0;
  int         n_tests = 0;
  always #25 clk = ~clk;
  cmp_far_side #(.DIV(4), .DLY(30)) cmp_far_side_inst (.clk_i(clk), .above_i(ab),
    .tmr_run_i(run), .raw_o(raw), .tmr_o(tmr));
  cmp_control cmp_control_inst (.CLK_I(clk), .RESETN_I(rst_n), .ADDR_I(adr), .WDATA_I(wd),
    .WR_I(wr), .RD_I(rd), .CMP_RAW_I(raw), .TMR_CLK_I(tmr), .PIN_DIR_I(dir), .RDATA_O(rdat),
    .CMP_ENABLE_O(en), .CMP_HYST_O(hys), .CMP_SPEED_O(spd), .CMP_POS_SEL_O(psel),
    .CMP_NEG_SEL_O(nsel), .CMP_GATE_O(gate), .PIN_OUT_O(pout), .PIN_OE_N_O(oen), .IRQ_O(irq));
  task automatic w(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic wrr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    adr <= a;
    wd <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rc(input logic [2:0] a, input logic [7:0] e);
    @(posedge clk);
    rd <= 1'b1;
    adr <= a;
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
    chk("rdata", e, rdat);
  endtask
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial begin
    w(8);
    rst_n <= 1'b1;
    w(3);
    chk("spd", 8'h03, {6'h00, spd});
    rc(0, 8'h04);
    rc(4, 8'h00);
    wrr(7, 8'hFF);
    rc(7, 8'h00);
    wrr(0, 8'hFE);
    wrr(1, 8'h00);
    w(8);
    rc(0, 8'hF6);
    chk("en", 8'h01, {6'h00, en});
    chk("hys", 8'h01, {6'h00, hys});
    chk("spd", 8'h01, {6'h00, spd});
    dir <= 2'h0;
    wrr(1, 8'h20);
    w(2);
    chk("oen", 8'h00, {6'h00, oen});
    chk("pout", 8'h01, {6'h00, pout});
    dir <= 2'h3;
    for (k = 8'h00; k < 8'h04; k++) begin
      wrr(3, 8'h11 * k);
      w(2);
      chk("psel", k, {6'h00, psel[3:2]});
      chk("nsel", k, {6'h00, nsel[3:2]});
    end
    wrr(2, 8'hFF);
    rc(2, 8'hF3);
    wrr(6, 8'h03);
    rc(5, 8'h00);
    ab <= 2'h1;
    w(10);
    chk("irq", 8'h01, {7'h00, irq});
    rc(5, 8'h01);
    rc(5, 8'h00);
    chk("irq", 8'h00, {7'h00, irq});
    wrr(2, 8'h80);
    ab <= 2'h0;
    w(10);
    rc(5, 8'h01);
    rc(4, 8'h01);
    ab <= 2'h1;
    w(10);
    rc(5, 8'h00);
    wrr(3, 8'h80);
    wrr(1, 8'h10);
    w(10);
    rc(5, 8'h02);
    rc(4, 8'h02);
    chk("en", 8'h01, {6'h00, en});
    wrr(6, 8'h00);
    ab <= 2'h0;
    w(10);
    chk("irq", 8'h00, {7'h00, irq});
    rc(5, 8'h01);
    ab <= 2'h1;
    w(10);
    // Edge event lands on the same edge as the flag-clearing read
    ab <= 2'h0;
    w(3);
    rc(5, 8'h00);
    rc(5, 8'h01);
    wrr(0, 8'h95);
    w(10);
    chk("gate", 8'h02, {6'h00, gate});
    run <= 1'b1;
    w(14);
    chk("gate", 8'h03, {6'h00, gate});
    run <= 1'b0;
    ab <= 2'h1;
    w(10);
    chk("gate", 8'h03, {6'h00, gate});
    end_of_test;
  end
endmodule // tb_cmp_control
